//--- rtl/gcfc_pkg.sv
// Package with the constants, types and helpers of the command flow block.
//
// Contract
// R1: Interrupt pulse on rising command-write-enable flag.
// R2: Host waits for write-enable before new command.
// R3: Running command keeps its old buffered settings.
// R4: Staged settings apply only at command change.
// R5: Empty input FIFO stalls processing, never errors.
// R6: Host watches FIFO flags to avoid overrun.
// R7: Words are collected into blocks before processing.
// R8: Next command flushes input FIFO and buffers.
// R9: Block size from request count or physical config.
// R10: New command ends old one, then starts.
// R11: Null command flushes, starts no new work.
// R12: Partial read blocks appear only after flush.
// R13: Request count zero gives single transfers.
// R14: Read block waits for enough output space.
// R15: Host splits large reads into bounded packages.
// R16: Host respects package limit on bulk reads.
// R17: Physical read ignores request-count output blocking.
// R18: Readable chip identification bit tells FIFO depth.
// R19: Input and output FIFO, equal depth.
// R20: Write-enable reads zero with two commands queued.
// R21: FIFO empty and limit flags always readable.
`default_nettype none
package gcfc_pkg;
  // FIFO geometry, fixed at the 128-word variant.
  localparam int unsigned DEPTH = 128;
  localparam int unsigned PTR_W = 7;
  localparam int unsigned CNT_W = 8;
  typedef logic [PTR_W-1:0] gcfc_ptr_t;
  typedef logic [CNT_W-1:0] gcfc_cnt_t;
  typedef logic [31:0] gcfc_word_t;
  localparam gcfc_cnt_t DEPTH_CNT = 8'h80;
  // Chip identification bit: zero means the 128-word depth.
  localparam logic CHIP_ID = 1'b0;
  // Register offsets on the plain register port.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STAGE = 8'h04;
  localparam logic [7:0] OFS_REQCNT = 8'h08;
  localparam logic [7:0] OFS_PACFG = 8'h0c;
  localparam logic [7:0] OFS_OFLIM = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_IFIFO = 8'h18;
  localparam logic [7:0] OFS_OFIFO = 8'h1c;
  // Flag register bit positions.
  localparam int FLG_CWEN = 0;
  localparam int FLG_IFE = 1;
  localparam int FLG_OFE = 2;
  localparam int FLG_OFH = 3;
  localparam int FLG_IFF = 4;
  localparam int FLG_OFF = 5;
  localparam int FLG_ID = 6;
  // Reset values of the settings.
  localparam logic [6:0] REQCNT_RST = 7'h0f;
  localparam logic [6:0] PACFG_RST = 7'h07;
  localparam gcfc_cnt_t OFLIM_RST = 8'h40;
  // Command codes as written to the command register.
  localparam logic [7:0] CODE_LINE = 8'h01;
  localparam logic [7:0] CODE_PXRD = 8'h02;
  localparam logic [7:0] CODE_PXXCH = 8'h03;
  localparam logic [7:0] CODE_PHWR = 8'h04;
  localparam logic [7:0] CODE_PHRD = 8'h05;
  // Decoded commands; CMD_LINE stands for all pixel writers.
  typedef enum logic [2:0] {
    CMD_NULL, CMD_LINE, CMD_PXRD, CMD_PXXCH, CMD_PHWR, CMD_PHRD
  } gcfc_cmd_e;
  // Engine states of the top block.
  typedef enum logic [1:0] {ENG_COLLECT, ENG_EMIT, ENG_PHYS} gcfc_eng_e;
  // One register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    gcfc_word_t wdata;
  } gcfc_bus_s;
  // State of one FIFO.
  typedef struct packed {
    gcfc_word_t [DEPTH-1:0] mem;
    gcfc_ptr_t wp;
    gcfc_ptr_t rp;
    gcfc_cnt_t cnt;
  } gcfc_fifo_s;
  // State of the two-stage command pipeline.
  typedef struct packed {
    gcfc_cmd_e run;
    gcfc_cmd_e pend;
    logic pend_v;
    logic [7:0] code;
    gcfc_word_t stage;
    gcfc_word_t active;
    logic cwen;
    logic rise;
    logic start;
  } gcfc_pipe_s;
  // Unknown codes run as the null command.
  function automatic gcfc_cmd_e decode(input logic [7:0] code);
    case (code)
      CODE_LINE: decode = CMD_LINE;
      CODE_PXRD: decode = CMD_PXRD;
      CODE_PXXCH: decode = CMD_PXXCH;
      CODE_PHWR: decode = CMD_PHWR;
      CODE_PHRD: decode = CMD_PHRD;
      default: decode = CMD_NULL;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- rtl/gcfc_fifo.sv
// Flip-flop FIFO used for both the input and the output data path.
`default_nettype none
module gcfc_fifo (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic push_i,
  input wire gcfc_pkg::gcfc_word_t din_i,
  input wire logic pop_i,
  output gcfc_pkg::gcfc_word_t dout_o,
  output gcfc_pkg::gcfc_cnt_t cnt_o
);
  gcfc_pkg::gcfc_fifo_s s_r; // Whole FIFO state.
  gcfc_pkg::gcfc_fifo_s s_nxt; // Its next value.
  logic do_push; // Push that fits.
  logic do_pop; // Pop that has data.

  ////////////////////////////////////////////////////////////////////////////
  // A push to a full FIFO or a pop from an empty one is dropped, so a
  // careless host loses data but never corrupts the pointers.
  always_comb begin
    s_nxt = s_r;
    do_push = push_i && (s_r.cnt != gcfc_pkg::DEPTH_CNT);
    do_pop = pop_i && (s_r.cnt != '0);
    if (do_push) begin
      s_nxt.mem[s_r.wp] = din_i;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (do_pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout_o = s_r.mem[s_r.rp];
  assign cnt_o = s_r.cnt;
endmodule
`default_nettype wire

//--- rtl/gcfc_cmd_pipe.sv
// Two-stage command pipeline with staged command-buffered settings.
`default_nettype none
module gcfc_cmd_pipe (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cmd_wr_i,
  input wire logic stage_wr_i,
  input wire gcfc_pkg::gcfc_word_t wdata_i,
  input wire logic advance_i,
  output gcfc_pkg::gcfc_pipe_s st_o
);
  gcfc_pkg::gcfc_pipe_s s_r; // Pipeline state.
  gcfc_pkg::gcfc_pipe_s s_nxt; // Its next value.

  ////////////////////////////////////////////////////////////////////////////
  // Advance and accept are exclusive: advance needs a pending command and
  // accept needs the write-enable flag, which is low exactly then.
  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    // The engine says the old command is done: promote the pending one.
    if (advance_i && s_r.pend_v) begin
      s_nxt.run = s_r.pend; // R10
      s_nxt.pend_v = 1'b0;
      s_nxt.active = s_r.stage; // R4
      s_nxt.start = 1'b1;
    end
    // The staging copy may change at any time; the running one does not.
    if (stage_wr_i) begin
      s_nxt.stage = wdata_i; // R3
    end
    // A command written without the flag is ignored.
    if (cmd_wr_i && s_r.cwen) begin
      s_nxt.pend = gcfc_pkg::decode(wdata_i[7:0]);
      s_nxt.pend_v = 1'b1;
      s_nxt.code = wdata_i[7:0];
    end
    s_nxt.cwen = !s_nxt.pend_v; // R20
    s_nxt.rise = s_nxt.cwen && !s_r.cwen; // R1
  end

  // State register; the null command runs after reset with the flag high.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.cwen <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign st_o = s_r;
endmodule
`default_nettype wire

//--- rtl/gcfc_top.sv
// Command flow controller: register port, FIFOs and the collect engine.
`default_nettype none
module gcfc_top (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] ADDR_I,
  input wire gcfc_pkg::gcfc_word_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output gcfc_pkg::gcfc_word_t RDATA_O,
  output logic CWEN_RISE_O,
  output logic MEM_XFER_O,
  output logic MEM_BURST_O
);

  ////////////////////////////////////////////////////////////////////////////
  // State of this module.

  // All engine state and the reqcnt, pacfg and oflim settings in one struct.
  typedef struct packed {
    gcfc_pkg::gcfc_eng_e state;
    gcfc_pkg::gcfc_cnt_t coll;
    gcfc_pkg::gcfc_cnt_t left;
    gcfc_pkg::gcfc_cnt_t idx;
    gcfc_pkg::gcfc_cnt_t phys_left;
    gcfc_pkg::gcfc_word_t phys_addr;
    gcfc_pkg::gcfc_word_t [gcfc_pkg::DEPTH-1:0] buffer;
    logic [6:0] reqcnt;
    logic [6:0] pacfg;
    gcfc_pkg::gcfc_cnt_t oflim;
    gcfc_pkg::gcfc_word_t rdata;
    logic xfer;
    logic burst;
  } gcfc_top_s;

  gcfc_top_s s_r; // Registered state.
  gcfc_top_s s_nxt; // Next state.
  gcfc_pkg::gcfc_bus_s bus; // Bundled register request.
  gcfc_pkg::gcfc_pipe_s pipe; // Command pipeline state.

  // FIFO connections.
  logic in_push; // Host word into the input FIFO.
  logic in_pop; // Engine takes a word.
  gcfc_pkg::gcfc_word_t in_dout; // Head of the input FIFO.
  gcfc_pkg::gcfc_cnt_t in_cnt; // Input FIFO fill.
  logic out_push; // Engine writes a result.
  gcfc_pkg::gcfc_word_t out_din; // Result word.
  logic out_pop; // Host reads a result.
  gcfc_pkg::gcfc_word_t out_dout; // Head of the output FIFO.
  gcfc_pkg::gcfc_cnt_t out_cnt; // Output FIFO fill.

  // Helper terms.
  logic cmd_wr; // Command register write.
  logic stage_wr; // Staging register write.
  logic accept; // Command actually taken.
  logic advance; // Old command finished.
  logic consumes; // Running command eats input words.
  logic is_read; // Running pixel command returns results.
  logic blk_full; // Current block reached its size.
  logic blk_tail; // Flush of a partial block.
  gcfc_pkg::gcfc_cnt_t bsz; // Block size of the running command.
  gcfc_pkg::gcfc_cnt_t out_free; // Free output entries.
  gcfc_pkg::gcfc_word_t flags; // Flag register image.

  ////////////////////////////////////////////////////////////////////////////
  // Request bundling and address decode.

  // The port signals are bundled once so all decode reads one place.
  always_comb begin
    bus.wr = WR_I;
    bus.rd = RD_I;
    bus.addr = ADDR_I;
    bus.wdata = WDATA_I;
  end

  assign cmd_wr = bus.wr && (bus.addr == gcfc_pkg::OFS_CMD);
  assign stage_wr = bus.wr && (bus.addr == gcfc_pkg::OFS_STAGE);
  assign in_push = bus.wr && (bus.addr == gcfc_pkg::OFS_IFIFO);
  assign out_pop = bus.rd && (bus.addr == gcfc_pkg::OFS_OFIFO);
  assign accept = cmd_wr && pipe.cwen;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.

  // Input FIFO; the host paces itself on the flags.
  gcfc_fifo u_in_fifo (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .push_i(in_push), // R6
    .din_i(bus.wdata),
    .pop_i(in_pop),
    .dout_o(in_dout),
    .cnt_o(in_cnt)
  );

  // Output FIFO of the same depth.
  gcfc_fifo u_out_fifo ( // R19
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .push_i(out_push),
    .din_i(out_din),
    .pop_i(out_pop),
    .dout_o(out_dout),
    .cnt_o(out_cnt)
  );

  // Command register, shadow register and settings.
  gcfc_cmd_pipe u_pipe (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .cmd_wr_i(cmd_wr),
    .stage_wr_i(stage_wr),
    .wdata_i(bus.wdata),
    .advance_i(advance),
    .st_o(pipe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command classes and block size.

  // Pixel commands use the request count, physical ones their own size.
  always_comb begin
    consumes = (pipe.run == gcfc_pkg::CMD_LINE) ||
               (pipe.run == gcfc_pkg::CMD_PXRD) ||
               (pipe.run == gcfc_pkg::CMD_PXXCH) ||
               (pipe.run == gcfc_pkg::CMD_PHWR);
    is_read = (pipe.run == gcfc_pkg::CMD_PXRD) ||
              (pipe.run == gcfc_pkg::CMD_PXXCH);
    if ((pipe.run == gcfc_pkg::CMD_PHWR) || (pipe.run == gcfc_pkg::CMD_PHRD)) begin
      bsz = {1'b0, s_r.pacfg} + 8'h01; // R9
    end else begin
      bsz = {1'b0, s_r.reqcnt} + 8'h01; // R9
    end
    out_free = gcfc_pkg::DEPTH_CNT - out_cnt;
    // A size lowered mid-block still closes the block at once.
    blk_full = (s_r.coll >= bsz);
    blk_tail = pipe.pend_v && (s_r.left == '0) && (s_r.coll != '0); // R12
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag register image.

  // Flags are live levels; the host may sample them at any time.
  always_comb begin
    flags = '0;
    flags[gcfc_pkg::FLG_CWEN] = pipe.cwen; // R20
    flags[gcfc_pkg::FLG_IFE] = (in_cnt == '0); // R21
    flags[gcfc_pkg::FLG_OFE] = (out_cnt == '0); // R21
    flags[gcfc_pkg::FLG_OFH] = (out_cnt >= s_r.oflim); // R21
    flags[gcfc_pkg::FLG_IFF] = (in_cnt == gcfc_pkg::DEPTH_CNT);
    flags[gcfc_pkg::FLG_OFF] = (out_cnt == gcfc_pkg::DEPTH_CNT);
    flags[gcfc_pkg::FLG_ID] = gcfc_pkg::CHIP_ID; // R18
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: register port and engine.

  // One process computes every next value of the module state.
  always_comb begin
    s_nxt = s_r;
    s_nxt.xfer = 1'b0;
    s_nxt.rdata = '0;
    in_pop = 1'b0;
    out_push = 1'b0;
    out_din = '0;
    advance = 1'b0;

    // Settings writes; the command and FIFO ports are decoded above.
    if (bus.wr) begin
      case (bus.addr)
        gcfc_pkg::OFS_REQCNT: s_nxt.reqcnt = bus.wdata[6:0];
        gcfc_pkg::OFS_PACFG: s_nxt.pacfg = bus.wdata[6:0];
        gcfc_pkg::OFS_OFLIM: s_nxt.oflim = bus.wdata[7:0];
        default: s_nxt.reqcnt = s_r.reqcnt;
      endcase
    end

    // Read data stand for one cycle only; unmapped offsets read zero.
    if (bus.rd) begin
      case (bus.addr)
        gcfc_pkg::OFS_CMD: s_nxt.rdata = {24'h000000, pipe.code};
        gcfc_pkg::OFS_STAGE: s_nxt.rdata = pipe.stage;
        gcfc_pkg::OFS_REQCNT: s_nxt.rdata = {25'h0000000, s_r.reqcnt};
        gcfc_pkg::OFS_PACFG: s_nxt.rdata = {25'h0000000, s_r.pacfg};
        gcfc_pkg::OFS_OFLIM: s_nxt.rdata = {24'h000000, s_r.oflim};
        gcfc_pkg::OFS_FLAGS: s_nxt.rdata = flags;
        gcfc_pkg::OFS_OFIFO: s_nxt.rdata = out_dout;
        default: s_nxt.rdata = '0;
      endcase
    end

    // Engine.
    case (s_r.state)
      // Collect words into the block buffer and decide what to do with it.
      gcfc_pkg::ENG_COLLECT: begin
        if (pipe.start && (pipe.run == gcfc_pkg::CMD_PHRD)) begin
          // The finite read knows its length up front.
          s_nxt.state = gcfc_pkg::ENG_PHYS; // R17
          s_nxt.phys_left = bsz;
        end else if (consumes) begin
          if (blk_full || blk_tail) begin
            if (is_read) begin
              // Results leave only as a whole block with room for all.
              if (out_free >= s_r.coll) begin
                s_nxt.state = gcfc_pkg::ENG_EMIT; // R14
                s_nxt.idx = '0;
              end
            end else begin
              // A write block goes out as one memory transfer.
              s_nxt.xfer = 1'b1; // R7
              s_nxt.burst = (s_r.coll != 8'h01); // R13
              s_nxt.coll = '0;
            end
          end else if ((in_cnt != '0) && (!pipe.pend_v || (s_r.left != '0))) begin
            // Take a word; words beyond the old command's share wait.
            in_pop = 1'b1;
            s_nxt.buffer[s_r.coll[6:0]] = in_dout;
            s_nxt.coll = s_r.coll + 8'h01;
            if (pipe.pend_v) begin
              s_nxt.left = s_r.left - 8'h01; // R8
            end
          end else if (pipe.pend_v && (s_r.left == '0) && (s_r.coll == '0)) begin
            // Everything of the old command is processed.
            advance = 1'b1; // R10
          end
          // With an empty FIFO and no new command the engine just waits.
          // R5
        end else if (pipe.pend_v) begin
          // Null command: nothing to flush, its words stay queued.
          advance = 1'b1; // R11
        end
      end
      // Emit a finished read block, one word a cycle.
      gcfc_pkg::ENG_EMIT: begin
        out_push = 1'b1;
        if (pipe.run == gcfc_pkg::CMD_PXXCH) begin
          out_din = s_r.buffer[s_r.idx[6:0]] ^ pipe.active; // R3
        end else begin
          out_din = s_r.buffer[s_r.idx[6:0]];
        end
        s_nxt.idx = s_r.idx + 8'h01;
        if (s_nxt.idx >= s_r.coll) begin
          s_nxt.state = gcfc_pkg::ENG_COLLECT;
          s_nxt.coll = '0;
          s_nxt.xfer = 1'b1;
          s_nxt.burst = (s_r.coll != 8'h01); // R13
        end
      end
      // Finite read streams word by word as space allows.
      gcfc_pkg::ENG_PHYS: begin
        if (s_r.phys_left == '0) begin
          s_nxt.state = gcfc_pkg::ENG_COLLECT;
        end else if (out_cnt != gcfc_pkg::DEPTH_CNT) begin
          out_push = 1'b1; // R17
          out_din = s_r.phys_addr;
          s_nxt.phys_addr = s_r.phys_addr + 32'h00000001;
          s_nxt.phys_left = s_r.phys_left - 8'h01;
          s_nxt.xfer = 1'b1;
          s_nxt.burst = 1'b0;
        end
      end
      default: s_nxt.state = gcfc_pkg::ENG_COLLECT;
    endcase

    // On accept, the words now queued belong to the old command.
    if (accept) begin
      s_nxt.left = in_cnt - {7'h00, in_pop}; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset puts every setting at its reset value and the engine idle.
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_r <= '0;
      s_r.reqcnt <= gcfc_pkg::REQCNT_RST;
      s_r.pacfg <= gcfc_pkg::PACFG_RST;
      s_r.oflim <= gcfc_pkg::OFLIM_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.

  assign RDATA_O = s_r.rdata;
  assign CWEN_RISE_O = pipe.rise; // R1
  assign MEM_XFER_O = s_r.xfer;
  assign MEM_BURST_O = s_r.burst;
endmodule
`default_nettype wire

//--- verif/gcfc_assertions.sv
// Checker with the port-level properties of the command flow block.
`default_nettype none
module gcfc_assertions (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] ADDR_I,
  input wire gcfc_pkg::gcfc_word_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire gcfc_pkg::gcfc_word_t RDATA_O,
  input wire logic CWEN_RISE_O,
  input wire logic MEM_XFER_O,
  input wire logic MEM_BURST_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] reqcnt_r; // Last request count written by software.
  logic [6:0] pacfg_r; // Last physical block setting written.
  logic pend_r; // A command write was seen since the last rise pulse.
  logic cmd_wr; // This cycle writes the command register.
  logic flg_rd; // This cycle reads the flag register.
  assign cmd_wr = WR_I && (ADDR_I == gcfc_pkg::OFS_CMD);
  assign flg_rd = RD_I && (ADDR_I == gcfc_pkg::OFS_FLAGS);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow the block size settings; they only matter once both are zero.
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      reqcnt_r <= gcfc_pkg::REQCNT_RST;
      pacfg_r <= gcfc_pkg::PACFG_RST;
      pend_r <= 1'b0;
    end else begin
      if (WR_I && ADDR_I == gcfc_pkg::OFS_REQCNT) reqcnt_r <= WDATA_I[6:0];
      if (WR_I && ADDR_I == gcfc_pkg::OFS_PACFG) pacfg_r <= WDATA_I[6:0];
      // A new write wins over a pulse in the same cycle.
      if (cmd_wr) pend_r <= 1'b1;
      else if (CWEN_RISE_O) pend_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == '0)
    else $error("read data not zero outside a read answer");
  rise_pulse_a: assert property (CWEN_RISE_O |=> !CWEN_RISE_O)
    else $error("write enable rise pulse longer than one cycle");
  chip_id_a: assert property (flg_rd |=> RDATA_O[gcfc_pkg::FLG_ID] == gcfc_pkg::CHIP_ID)
    else $error("chip id bit wrong");
  rise_cause_a: assert property (CWEN_RISE_O |-> pend_r)
    else $error("rise pulse without an accepted command");
  rise_gap_a: assert property (cmd_wr |=> !CWEN_RISE_O)
    else $error("rise pulse right after a command write");
  burst_single_a: assert property (MEM_XFER_O && reqcnt_r == 7'h00 && pacfg_r == 7'h00
    |-> !MEM_BURST_O) else $error("burst with zero request count");
  burst_hold_a: assert property (!MEM_XFER_O |-> $stable(MEM_BURST_O))
    else $error("burst level changed without a transfer");
  flags_excl_a: assert property (flg_rd |=> !(RDATA_O[1] && RDATA_O[4])
    && !(RDATA_O[2] && RDATA_O[5])) else $error("fifo empty and full together");
  // Main scenarios reached.
  cover property (CWEN_RISE_O);
  cover property (MEM_XFER_O && MEM_BURST_O);
  cover property (MEM_XFER_O && !MEM_BURST_O);
endmodule
bind gcfc_top gcfc_assertions u_chk (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CWEN_RISE_O(CWEN_RISE_O),
  .MEM_XFER_O(MEM_XFER_O), .MEM_BURST_O(MEM_BURST_O));
`default_nettype wire

//--- verif/gcfc_host_model.sv
// Host processor model that drives the register port of the command flow block.
`default_nettype none
module gcfc_host_model (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output gcfc_pkg::gcfc_word_t wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire gcfc_pkg::gcfc_word_t rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero.
  initial begin
    addr_o <= 8'h00;
    wdata_o <= 32'h0;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  end
  // One write cycle; stale data is inverted so it never looks valid.
  task automatic wr(input logic [7:0] a, input gcfc_pkg::gcfc_word_t d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // One read cycle; the answer stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output gcfc_pkg::gcfc_word_t d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
  // Bounded poll of one flag bit, so a stuck flag cannot hang the run.
  task automatic poll(input int n, input logic lvl, output logic ok);
    gcfc_pkg::gcfc_word_t f;
    ok = 1'b0;
    for (int i = 0; i < 600 && !ok; i++) begin
      rd(gcfc_pkg::OFS_FLAGS, f);
      ok = (f[n] === lvl);
    end
  endtask
  // Command write only once the write enable flag is up.
  task automatic cmd(input logic [7:0] code, output logic ok);
    poll(gcfc_pkg::FLG_CWEN, 1'b1, ok);
    if (ok) wr(gcfc_pkg::OFS_CMD, {24'h0, code});
  endtask
  // Data push only while the input FIFO is not full.
  task automatic push(input gcfc_pkg::gcfc_word_t d, output logic ok);
    poll(gcfc_pkg::FLG_IFF, 1'b0, ok);
    if (ok) wr(gcfc_pkg::OFS_IFIFO, d);
  endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking testbench of the command flow block driven by the host model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] a; gcfc_pkg::gcfc_word_t d;
    gcfc_pkg::gcfc_word_t e;} gcfc_row_s;
  logic sys_clk, rstn, wr, rd, rise, xfer, burst, ok;
  logic [7:0] addr;
  gcfc_pkg::gcfc_word_t wdata, rdata, got;
  int error_cnt = 0, check_count = 0, xfer_n = 0, burst_n = 0, rise_n = 0, n0, b0, r0;
  // Register rows: address, written value, value expected back.
  gcfc_row_s rows [7] = '{'{gcfc_pkg::OFS_FLAGS, 32'hffff_ffff, 32'h07},
    '{gcfc_pkg::OFS_STAGE, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
    '{gcfc_pkg::OFS_REQCNT, 32'hffff_ffff, 32'h7f},
    '{gcfc_pkg::OFS_PACFG, 32'h0000_0085, 32'h05},
    '{gcfc_pkg::OFS_OFLIM, 32'h0000_01ff, 32'hff},
    '{gcfc_pkg::OFS_OFLIM, 32'h0000_0080, 32'h80}, '{8'hf0, 32'h1234_5678, 32'h0}};
  gcfc_top uut (.SYS_CLK_I(sys_clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .CWEN_RISE_O(rise), .MEM_XFER_O(xfer), .MEM_BURST_O(burst));
  gcfc_host_model host (.clk_i(sys_clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  ////////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Count pulses on the falling edge, away from the design's updates.
  always @(negedge sys_clk) begin
    if (xfer === 1'b1) xfer_n++;
    if (xfer === 1'b1 && burst === 1'b1) burst_n++;
    if (rise === 1'b1) rise_n++;
  end
  // One comparison; four-state so an unknown never matches.
  task automatic chk(input gcfc_pkg::gcfc_word_t g, input gcfc_pkg::gcfc_word_t e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input gcfc_pkg::gcfc_word_t e);
    host.rd(a, got);
    chk(got, e);
  endtask
  // Wait for the transfer pulses under a bound, then compare the count.
  task automatic wait_xfer(input int n);
    for (int i = 0; i < 3000 && xfer_n < n; i++) @(posedge sys_clk);
    chk(32'(xfer_n), 32'(n));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The whole run needs well under 20 us.
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rdchk(gcfc_pkg::OFS_REQCNT, 32'h0f);
    rdchk(gcfc_pkg::OFS_PACFG, 32'h07);
    rdchk(gcfc_pkg::OFS_FLAGS, 32'h07);
    $display("test reset done");
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    $display("test rows done");
    // Zero request count: one single transfer per word, with slow data.
    host.wr(gcfc_pkg::OFS_REQCNT, 32'h0);
    host.wr(gcfc_pkg::OFS_PACFG, 32'h0);
    host.cmd(gcfc_pkg::CODE_PXRD, ok);
    n0 = xfer_n;
    b0 = burst_n;
    for (int i = 0; i < 3; i++) host.push(32'h100 + i, ok);
    wait_xfer(n0 + 3);
    chk(32'(burst_n - b0), 32'h0);
    for (int i = 0; i < 3; i++) rdchk(gcfc_pkg::OFS_OFIFO, 32'h100 + i);
    $display("test single done");
    // Exchange in blocks of four; a staged setting must not reach the running command.
    host.wr(gcfc_pkg::OFS_REQCNT, 32'h3);
    host.wr(gcfc_pkg::OFS_STAGE, 32'h0000_ffff);
    host.cmd(gcfc_pkg::CODE_PXXCH, ok);
    host.poll(gcfc_pkg::FLG_CWEN, 1'b1, ok);
    host.wr(gcfc_pkg::OFS_STAGE, 32'hffff_0000);
    n0 = xfer_n;
    b0 = burst_n;
    for (int i = 0; i < 6; i++) host.push(32'h200 + i, ok);
    wait_xfer(n0 + 1);
    chk(32'(burst_n - b0), 32'h1);
    for (int i = 0; i < 4; i++) rdchk(gcfc_pkg::OFS_OFIFO, (32'h200 + i) ^ 32'hffff);
    host.rd(gcfc_pkg::OFS_FLAGS, got);
    chk({31'h0, got[gcfc_pkg::FLG_OFE]}, 32'h1);
    host.cmd(8'h00, ok);
    host.poll(gcfc_pkg::FLG_CWEN, 1'b1, ok);
    chk({31'h0, ok}, 32'h1);
    for (int i = 4; i < 6; i++) rdchk(gcfc_pkg::OFS_OFIFO, (32'h200 + i) ^ 32'hffff);
    $display("test exchange done");
    // Physical read takes its size from its own setting.
    host.wr(gcfc_pkg::OFS_PACFG, 32'h3);
    n0 = xfer_n;
    host.cmd(gcfc_pkg::CODE_PHRD, ok);
    wait_xfer(n0 + 4);
    for (int i = 0; i < 4; i++) rdchk(gcfc_pkg::OFS_OFIFO, 32'(i));
    $display("test phys done");
    // Fill the output FIFO, then a block must wait for room.
    n0 = xfer_n;
    r0 = rise_n;
    host.cmd(gcfc_pkg::CODE_PXRD, ok);
    for (int i = 0; i < 128; i++) host.push(32'(i), ok);
    wait_xfer(n0 + 32);
    host.rd(gcfc_pkg::OFS_FLAGS, got);
    chk(got & 32'h2f, 32'h2b);
    for (int i = 128; i < 132; i++) host.push(32'(i), ok);
    host.cmd(8'h00, ok);
    host.wr(gcfc_pkg::OFS_CMD, {24'h0, gcfc_pkg::CODE_LINE});
    rdchk(gcfc_pkg::OFS_CMD, 32'h0);
    host.rd(gcfc_pkg::OFS_FLAGS, got);
    chk({31'h0, got[gcfc_pkg::FLG_CWEN]}, 32'h0);
    chk(32'(xfer_n), 32'(n0 + 32));
    for (int i = 0; i < 132; i++) rdchk(gcfc_pkg::OFS_OFIFO, 32'(i));
    host.poll(gcfc_pkg::FLG_CWEN, 1'b1, ok);
    chk(32'(rise_n - r0), 32'h2);
    $display("test blocking done");
    // Line draw, then physical write: both close a block at four words.
    n0 = xfer_n;
    host.cmd(gcfc_pkg::CODE_LINE, ok);
    for (int i = 0; i < 4; i++) host.push(32'(i), ok);
    host.cmd(gcfc_pkg::CODE_PHWR, ok);
    for (int i = 0; i < 4; i++) host.push(32'(i), ok);
    wait_xfer(n0 + 2);
    $display("test write done");
    end_of_test();
  end
endmodule
`default_nettype wire
